// file: inc/crp_defs.svh
// constants for the codec reset and power-down controller
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH

// register file geometry
`define CRP_NREG 18
`define CRP_AW 8
`define CRP_DW 8
`define CRP_ZERO_BYTE 8'h00

// register numbers
`define CRP_REG_FIRST 1
`define CRP_REG_LAST 17
`define CRP_REG_C1 2
`define CRP_REG_C2 7
`define CRP_REG_SPK 11
`define CRP_REG_HS 13
`define CRP_REG_HD 14
`define CRP_REG_HPF1 15
`define CRP_REG_HPF2 16
`define CRP_REG_X17 17
`define CRP_G1_LO 1
`define CRP_G1_HI 5
`define CRP_G2_LO 6
`define CRP_G2_HI 14

// field positions
`define CRP_PD_BIT 0
`define CRP_SWRST_BIT 1
`define CRP_DRV_PD_BIT 7
`define CRP_LINE_PD_BIT 6
`define CRP_ST_HI 5
`define CRP_ST_LO 4
`define CRP_MG_HI 1
`define CRP_MG_LO 0
`define CRP_SG_HI 2
`define CRP_SG_LO 0

// reset values (sidetone field 2'h1 selects 14 dB)
`define CRP_DEF_PLAIN 8'h00
`define CRP_DEF_HS 8'h10
`define CRP_DEF_HD 8'h10

// wait after hardware reset release
`define CRP_RST_WAIT_US 10
`define CRP_CLK_MHZ 100
`define CRP_RST_WAIT_CYC (`CRP_RST_WAIT_US * `CRP_CLK_MHZ)
`define CRP_RST_CNT_W 10

`endif

// file: inc/crp_pkg.sv
// types shared by the codec reset and power-down controller
`include "crp_defs.svh"

package crp_pkg;

  typedef logic [`CRP_DW-1:0] crp_byte_t;

  // register write request from the control interface
  typedef struct packed {
    logic en;
    logic [`CRP_AW-1:0] addr;
    crp_byte_t data;
  } crp_wr_s;

  // output driver enables
  typedef struct packed {
    logic handset;
    logic headset;
    logic line;
    logic speaker;
  } crp_drv_s;

  typedef enum logic [1:0] {
    CRP_MG_0DB = 2'h0,
    CRP_MG_14DB = 2'h1,
    CRP_MG_23DB = 2'h2,
    CRP_MG_MUTE = 2'h3
  } crp_mic_gain_e;

  typedef enum logic [2:0] {
    CRP_SG_0DB = 3'h0,
    CRP_SG_20DB = 3'h1,
    CRP_SG_32DB = 3'h2,
    CRP_SG_42DB = 3'h3,
    CRP_SG_MUTE = 3'h4
  } crp_spk_gain_e;

  // preamplifier and sidetone settings
  typedef struct packed {
    crp_mic_gain_e handset_mic;
    crp_mic_gain_e headset_mic;
    crp_spk_gain_e speaker_mic;
    logic [1:0] handset_sidetone;
    logic [1:0] headset_sidetone;
  } crp_gain_s;

  // per-codec sequencer states, gray along run-hold-wait
  typedef enum logic [1:0] {
    CRP_RUN = 2'h0,
    CRP_HOLD = 2'h1,
    CRP_WAIT2 = 2'h3,
    CRP_WAIT1 = 2'h2
  } crp_cst_e;

  typedef struct packed {
    crp_cst_e st;
    logic cnt_rst;
    logic cm_hold;
    logic ready;
  } crp_codec_s;

  typedef struct packed {
    logic [`CRP_NREG-1:0][`CRP_DW-1:0] regs;
    logic pd_meta;
    logic pd_sync;
    logic [`CRP_RST_CNT_W-1:0] wait_cnt;
    logic wait_done;
    crp_drv_s drv;
    crp_gain_s gain;
    crp_byte_t rd_data;
    logic host_ready;
  } crp_top_s;

endpackage : crp_pkg

// file: rtl/crp_codec_seq.sv
// per-codec counter reset and data-acceptance sequencer
`timescale 1ns/1ps

module crp_codec_seq
  import crp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // controls
  input wire logic sw_reset,
  input wire logic codec_pd,
  input wire logic hw_pd,
  input wire logic fsync,
  // status
  output crp_codec_s stat_q
);

  crp_codec_s d;

  // power-down pin was the last hold source
  logic hw_last_q;

  function automatic logic was_hw();
    return hw_last_q;
  endfunction : was_hw

  always_comb
  begin
    d = stat_q;
    d.cm_hold = codec_pd;
    d.cnt_rst = sw_reset | codec_pd | hw_pd;
    case (stat_q.st)
      CRP_RUN:
      begin
        d.ready = 1'b1;
        if (sw_reset | codec_pd | hw_pd)
        begin
          d.st = CRP_HOLD;
          d.ready = 1'b0;
        end
      end
      CRP_HOLD:
      begin
        d.ready = 1'b0;
        if (hw_pd)
          d.st = CRP_HOLD;
        else if (stat_q.cnt_rst && !d.cnt_rst && stat_q.st == CRP_HOLD)
          d.st = CRP_WAIT1;
        else if (!d.cnt_rst)
          d.st = CRP_WAIT1;
      end
      CRP_WAIT2:
      begin
        d.ready = 1'b0;
        if (d.cnt_rst)
          d.st = CRP_HOLD;
        else if (fsync)
          d.st = CRP_WAIT1;
      end
      CRP_WAIT1:
      begin
        d.ready = 1'b0;
        if (d.cnt_rst)
          d.st = CRP_HOLD;
        else if (fsync)
        begin
          d.st = CRP_RUN;
          d.ready = 1'b1;
        end
      end
      default:
      begin
        d.st = CRP_HOLD;
        d.ready = 1'b0;
      end
    endcase
    // power-down pin release waits two frame syncs
    if (stat_q.st == CRP_HOLD && !d.cnt_rst && stat_q.cnt_rst
        && hw_pd == 1'b0 && !sw_reset && !codec_pd && was_hw())
      d.st = CRP_WAIT2;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      stat_q <= '{st: CRP_HOLD, cnt_rst: 1'b1, cm_hold: 1'b0, ready: 1'b0};
      hw_last_q <= 1'b0;
    end
    else if (clk_en)
    begin
      stat_q <= d;
      if (hw_pd)
        hw_last_q <= 1'b1;
      else if (stat_q.st != CRP_HOLD)
        hw_last_q <= 1'b0;
    end
  end

endmodule : crp_codec_seq

// file: rtl/crp_ctrl.sv
// codec reset and power-down controller with control register file
//
// Summary of operation
// - codec power-down holds its outputs at common mode
// - each output driver has its own power-down bit
// - reset pin low loads every register default
// - register 2 soft reset restores group one
// - register 7 soft reset restores group two
// - data accepted from frame after soft reset
// - handset/headset mic gain 0, 14, 23, mute
// - speakerphone mic gain 0, 20, 32, 42, mute
// - sidetone gains default to 14 dB
// - power-down pin resets counters, keeps registers
// - codec power-down resets counters, keeps registers
`timescale 1ns/1ps
`include "crp_defs.svh"

module crp_ctrl
  import crp_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // pins and frame timing
  input wire logic hw_powerdown_pin,
  input wire logic fsync,
  // register access from the control interface
  input crp_wr_s wr,
  input wire logic [`CRP_AW-1:0] rd_addr,
  output crp_byte_t rd_data_q,
  // codec sequencing
  output logic c1_cnt_rst_q,
  output logic c2_cnt_rst_q,
  output logic c1_cm_hold_q,
  output logic c2_cm_hold_q,
  output logic host_ready_q,
  // analog settings
  output crp_drv_s drv_en_q,
  output crp_gain_s gain_q
);

  crp_top_s q;
  crp_top_s d;
  crp_codec_s c1_q;
  crp_codec_s c2_q;

  //////////////////////////////////////////////////////////////////////////
  // register helpers

  function automatic crp_byte_t reg_default(input int idx);
    case (idx)
      `CRP_REG_HS: reg_default = `CRP_DEF_HS;
      `CRP_REG_HD: reg_default = `CRP_DEF_HD;
      default: reg_default = `CRP_DEF_PLAIN;
    endcase
  endfunction : reg_default

  function automatic logic in_group1(input int idx);
    in_group1 = (idx >= `CRP_G1_LO && idx <= `CRP_G1_HI)
                || idx == `CRP_REG_HPF1;
  endfunction : in_group1

  function automatic logic in_group2(input int idx);
    in_group2 = (idx >= `CRP_G2_LO && idx <= `CRP_G2_HI)
                || idx == `CRP_REG_HPF2 || idx == `CRP_REG_X17;
  endfunction : in_group2

  function automatic crp_mic_gain_e mic_gain(input logic [1:0] f);
    case (f)
      2'h0: mic_gain = CRP_MG_0DB;
      2'h1: mic_gain = CRP_MG_14DB;
      2'h2: mic_gain = CRP_MG_23DB;
      default: mic_gain = CRP_MG_MUTE;
    endcase
  endfunction : mic_gain

  function automatic crp_spk_gain_e spk_gain(input logic [2:0] f);
    case (f)
      3'h0: spk_gain = CRP_SG_0DB;
      3'h1: spk_gain = CRP_SG_20DB;
      3'h2: spk_gain = CRP_SG_32DB;
      3'h3: spk_gain = CRP_SG_42DB;
      default: spk_gain = CRP_SG_MUTE;
    endcase
  endfunction : spk_gain

  function automatic logic addr_mapped(input logic [`CRP_AW-1:0] a);
    addr_mapped = a >= `CRP_AW'(`CRP_REG_FIRST)
                  && a <= `CRP_AW'(`CRP_REG_LAST);
  endfunction : addr_mapped

  //////////////////////////////////////////////////////////////////////////
  // per-codec sequencers

  crp_codec_seq u_codec1 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .sw_reset(q.regs[`CRP_REG_C1][`CRP_SWRST_BIT]),
    .codec_pd(q.regs[`CRP_REG_C1][`CRP_PD_BIT]),
    .hw_pd(q.pd_sync),
    .fsync(fsync),
    .stat_q(c1_q)
  );

  crp_codec_seq u_codec2 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .sw_reset(q.regs[`CRP_REG_C2][`CRP_SWRST_BIT]),
    .codec_pd(q.regs[`CRP_REG_C2][`CRP_PD_BIT]),
    .hw_pd(q.pd_sync),
    .fsync(fsync),
    .stat_q(c2_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    d = q;

    // power-down pin synchroniser
    d.pd_meta = hw_powerdown_pin;
    d.pd_sync = q.pd_meta;

    // writes; register zero and unmapped numbers update nothing
    if (wr.en && addr_mapped(wr.addr))
      d.regs[wr.addr[4:0]] = wr.data;

    // soft resets hold their group at defaults while the bit stays set
    for (int i = `CRP_REG_FIRST; i <= `CRP_REG_LAST; i++)
    begin
      if (d.regs[`CRP_REG_C1][`CRP_SWRST_BIT] && in_group1(i)
          && i != `CRP_REG_C1)
        d.regs[i] = reg_default(i);
      if (d.regs[`CRP_REG_C2][`CRP_SWRST_BIT] && in_group2(i)
          && i != `CRP_REG_C2)
        d.regs[i] = reg_default(i);
    end
    if (d.regs[`CRP_REG_C1][`CRP_SWRST_BIT])
    begin
      d.regs[`CRP_REG_C1] = reg_default(`CRP_REG_C1);
      d.regs[`CRP_REG_C1][`CRP_SWRST_BIT] = 1'b1;
    end
    if (d.regs[`CRP_REG_C2][`CRP_SWRST_BIT])
    begin
      d.regs[`CRP_REG_C2] = reg_default(`CRP_REG_C2);
      d.regs[`CRP_REG_C2][`CRP_SWRST_BIT] = 1'b1;
    end

    // wait after hardware reset release
    if (!q.wait_done)
    begin
      if (q.wait_cnt == `CRP_RST_CNT_W'(`CRP_RST_WAIT_CYC - 1))
        d.wait_done = 1'b1;
      else
        d.wait_cnt = q.wait_cnt + `CRP_RST_CNT_W'(1);
    end

    // driver enables from power-down bits
    d.drv.handset = ~q.regs[`CRP_REG_HS][`CRP_DRV_PD_BIT];
    d.drv.headset = ~q.regs[`CRP_REG_HD][`CRP_DRV_PD_BIT];
    d.drv.line = ~q.regs[`CRP_REG_HD][`CRP_LINE_PD_BIT];
    d.drv.speaker = ~q.regs[`CRP_REG_SPK][`CRP_DRV_PD_BIT];

    // preamplifier and sidetone selections
    d.gain.handset_mic =
      mic_gain(q.regs[`CRP_REG_HS][`CRP_MG_HI:`CRP_MG_LO]);
    d.gain.headset_mic =
      mic_gain(q.regs[`CRP_REG_HD][`CRP_MG_HI:`CRP_MG_LO]);
    d.gain.speaker_mic =
      spk_gain(q.regs[`CRP_REG_SPK][`CRP_SG_HI:`CRP_SG_LO]);
    d.gain.handset_sidetone =
      q.regs[`CRP_REG_HS][`CRP_ST_HI:`CRP_ST_LO];
    d.gain.headset_sidetone =
      q.regs[`CRP_REG_HD][`CRP_ST_HI:`CRP_ST_LO];

    // read port, unmapped numbers read zero
    if (addr_mapped(rd_addr))
      d.rd_data = q.regs[rd_addr[4:0]];
    else
      d.rd_data = `CRP_ZERO_BYTE;

    d.host_ready = q.wait_done & c1_q.ready & c2_q.ready;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      q <= '0;
      for (int i = 0; i < `CRP_NREG; i++)
        q.regs[i] <= reg_default(i);
      q.drv <= '{handset: 1'b1, headset: 1'b1, line: 1'b1, speaker: 1'b1};
      q.gain <= '{handset_mic: CRP_MG_0DB, headset_mic: CRP_MG_0DB,
                  speaker_mic: CRP_SG_0DB,
                  handset_sidetone: 2'(`CRP_DEF_HS >> `CRP_ST_LO),
                  headset_sidetone: 2'(`CRP_DEF_HD >> `CRP_ST_LO)};
    end
    else if (clk_en)
      q <= d;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data_q = q.rd_data;
  assign host_ready_q = q.host_ready;
  assign drv_en_q = q.drv;
  assign gain_q = q.gain;
  assign c1_cnt_rst_q = c1_q.cnt_rst;
  assign c2_cnt_rst_q = c2_q.cnt_rst;
  assign c1_cm_hold_q = c1_q.cm_hold;
  assign c2_cm_hold_q = c2_q.cm_hold;

endmodule : crp_ctrl

// file: verif/crp_host_model.sv
// host side: frame pacing and send permission
`timescale 1ns/1ps
`include "crp_defs.svh"

module crp_host_model
  import crp_pkg::*;
#(
  parameter int FS_PER = 64
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // device status and frame timing
  input wire logic host_ready_q,
  output logic fsync,
  output logic tx_ok
);
  int fcnt = 0;
  int wcnt = 0;

  initial fsync = 1'b0;

  always @(posedge ref_clk)
  begin
    fcnt <= (fcnt + 1) % FS_PER;
    fsync <= (fcnt == 0);
    wcnt <= !rstn ? 0 : (wcnt < `CRP_RST_WAIT_CYC ? wcnt + 1 : wcnt);
  end

  // nothing is sent before the wait and the device's readiness
  assign tx_ok = host_ready_q && wcnt >= `CRP_RST_WAIT_CYC;
endmodule : crp_host_model

// file: verif/crp_ctrl_properties.sv
// assertions on the ports of the controller
`timescale 1ns/1ps
`include "crp_defs.svh"

module crp_ctrl_chk
  import crp_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // pins and register access
  input wire logic hw_powerdown_pin,
  input wire logic fsync,
  input crp_wr_s wr,
  input wire logic [`CRP_AW-1:0] rd_addr,
  input crp_byte_t rd_data_q,
  // status and settings
  input wire logic c1_cnt_rst_q,
  input wire logic c2_cnt_rst_q,
  input wire logic c1_cm_hold_q,
  input wire logic c2_cm_hold_q,
  input wire logic host_ready_q,
  input crp_drv_s drv_en_q,
  input crp_gain_s gain_q
);
  // first edge at which readiness may rise after reset release
  localparam int RST_RISE = `CRP_RST_WAIT_CYC + 1;
  // enabled cycles since reset release, saturating
  int since_rst;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      since_rst <= 0;
    else if (clk_en && since_rst <= RST_RISE)
      since_rst <= since_rst + 1;
  end

  a_ready_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
    since_rst < RST_RISE |-> !host_ready_q)
    else $error("ready before reset wait");
  a_rst_defaults: assert property (@(posedge ref_clk) !rstn && clk_en |=>
    drv_en_q == 4'hF && c1_cnt_rst_q && c2_cnt_rst_q && !host_ready_q &&
    gain_q.handset_sidetone == 2'h1 && gain_q.headset_sidetone == 2'h1)
    else $error("reset state wrong");
  a_hs_driver: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && wr.en && wr.addr == 8'h0D ##1 clk_en |=>
    drv_en_q.handset == !$past(wr.data[7], 2) &&
    gain_q.handset_mic == $past(wr.data[1:0], 2))
    else $error("handset setting wrong");
  a_spk_driver: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && wr.en && wr.addr == 8'h0B ##1 clk_en |=>
    drv_en_q.speaker == !$past(wr.data[7], 2) &&
    gain_q.speaker_mic == (($past(wr.data[2:0], 2) > 3'h4) ? 3'h4 :
    $past(wr.data[2:0], 2)))
    else $error("speaker setting wrong");
  a_c1_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && wr.en && wr.addr == 8'h02 && wr.data[1:0] != 2'h0
    ##1 clk_en |=> c1_cnt_rst_q &&
    c1_cm_hold_q == $past(wr.data[0] && !wr.data[1], 2))
    else $error("codec one not held");
  a_c2_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && wr.en && wr.addr == 8'h07 && wr.data[1:0] != 2'h0
    ##1 clk_en |=> c2_cnt_rst_q &&
    c2_cm_hold_q == $past(wr.data[0] && !wr.data[1], 2))
    else $error("codec two not held");
  a_ready_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && (c1_cnt_rst_q || c2_cnt_rst_q) |=> !host_ready_q)
    else $error("ready while counters held");
  a_ready_fsync: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(host_ready_q) |-> since_rst == RST_RISE ||
    $past(fsync, 2) || $past(fsync, 3) || $past(fsync, 4))
    else $error("ready without frame sync");
  a_pin_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(hw_powerdown_pin) ##1 hw_powerdown_pin[*4] |->
    c1_cnt_rst_q && c2_cnt_rst_q)
    else $error("pin power-down not seen");
endmodule : crp_ctrl_chk

bind crp_ctrl crp_ctrl_chk u_chk (.ref_clk, .rstn, .clk_en,
  .hw_powerdown_pin, .fsync, .wr, .rd_addr, .rd_data_q, .c1_cnt_rst_q,
  .c2_cnt_rst_q, .c1_cm_hold_q, .c2_cm_hold_q, .host_ready_q, .drv_en_q,
  .gain_q);

// file: verif/tb_top.sv
// self-checking bench for the codec reset and power-down controller
`timescale 1ns/1ps
`include "crp_defs.svh"

module tb_top
  import crp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic hw_powerdown_pin = 1'b0;
  logic fsync;
  logic tx_ok;
  crp_wr_s wr = '0;
  logic [`CRP_AW-1:0] rd_addr = 8'h00;
  crp_byte_t rd_data_q;
  logic c1_cnt_rst_q, c2_cnt_rst_q, c1_cm_hold_q, c2_cm_hold_q;
  logic host_ready_q;
  crp_drv_s drv_en_q;
  crp_gain_s gain_q;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] m [20];

  always #5 ref_clk = ~ref_clk;

  crp_ctrl u_crp_ctrl (.ref_clk, .rstn, .clk_en, .hw_powerdown_pin, .fsync,
    .wr, .rd_addr, .rd_data_q, .c1_cnt_rst_q, .c2_cnt_rst_q, .c1_cm_hold_q,
    .c2_cm_hold_q, .host_ready_q, .drv_en_q, .gain_q);
  crp_host_model u_crp_host_model (.ref_clk, .rstn, .host_ready_q, .fsync,
    .tx_ok);

  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [7:0] dflt(int i);
    return (i == 13 || i == 14) ? 8'h10 : 8'h00;
  endfunction : dflt

  // model: store, then force the groups held by a soft reset
  task automatic mdl_wr(int a, logic [7:0] d);
    logic s1;
    logic s2;
    if (clk_en && a > 0 && a < 18)
      m[a] = d;
    s1 = m[2][1];
    s2 = m[7][1];
    for (int i = 1; i < 18; i++)
      if (s1 && (i < 6 || i == 15))
        m[i] = dflt(i);
      else if (s2 && i > 5 && i != 15)
        m[i] = dflt(i);
    if (s1)
      m[2] = 8'h02;
    if (s2)
      m[7] = 8'h02;
  endtask : mdl_wr

  task automatic wr_reg(int a, logic [7:0] d);
    @(posedge ref_clk);
    wr <= '{1'b1, a[7:0], d};
    @(posedge ref_clk);
    wr.en <= 1'b0;
    mdl_wr(a, d);
  endtask : wr_reg

  task automatic wait_ready();
    int k;
    k = 0;
    while (!tx_ok && k < 5000)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk("ready", 8'h01, {7'h00, tx_ok});
  endtask : wait_ready

  task automatic check_all();
    logic [2:0] spk_exp;
    repeat (2) @(posedge ref_clk);
    #1;
    // speakerphone codes above the top gain select mute
    spk_exp = (m[11][2:0] > 3'h4) ? 3'h4 : m[11][2:0];
    chk("drv", {!m[13][7], !m[14][7], !m[14][6], !m[11][7]}, drv_en_q);
    chk("mic", {m[13][1:0], m[14][1:0], spk_exp}, gain_q[10:4]);
    chk("side", {m[13][5:4], m[14][5:4]}, gain_q[3:0]);
    chk("hold", {m[2][0], m[7][0]}, {c1_cm_hold_q, c2_cm_hold_q});
    for (int i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      rd_addr <= i[7:0];
      repeat (2) @(posedge ref_clk);
      #1;
      chk("reg", (i > 0 && i < 18) ? m[i] : 8'h00, rd_data_q);
    end
  endtask : check_all

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    void'($urandom(78245));
    for (int i = 0; i < 20; i++)
      m[i] = dflt(i);
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_ready();
    check_all();
    // random traffic with soft reset bits clear
    repeat (40)
    begin
      a = 8'($urandom_range(19));
      d = 8'($urandom);
      if (a == 8'h02 || a == 8'h07)
        d[1] = 1'b0;
      wr_reg(a, d);
    end
    check_all();
    for (int g = 0; g < 5; g++)
    begin
      wr_reg(11, g[7:0]);
      wr_reg(13, 8'(g % 4));
      wr_reg(14, 8'(3 - g % 4));
      check_all();
    end
    for (int c = 2; c < 8; c += 5)
    begin
      wr_reg(2, 8'h00);
      wr_reg(7, 8'h00);
      wr_reg(c, 8'h02);
      wr_reg(c + 1, 8'h5A);
      check_all();
      chk("cnt", 8'h01, {7'h00, c == 2 ? c1_cnt_rst_q : c2_cnt_rst_q});
      wr_reg(c, 8'h00);
      wait_ready();
    end
    wr_reg(3, 8'hA5);
    @(posedge ref_clk);
    hw_powerdown_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("pin", 8'h03, {6'h00, c1_cnt_rst_q, c2_cnt_rst_q});
    @(posedge ref_clk);
    hw_powerdown_pin <= 1'b0;
    wait_ready();
    check_all();
    // frozen clock enable: a write is not taken
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr_reg(5, 8'h77);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    check_all();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 20; i++)
      m[i] = dflt(i);
    wait_ready();
    check_all();
    print_verdict();
  end

  initial
  begin
    #500000;
    err_total++;
    print_verdict();
  end
endmodule : tb_top
